// ===== dv/pin_sharing_and_reset_pin_control_tb.sv
// Self-checking bench for the pin sharing and reset pin block.
`timescale 1ns/1ps
module pin_sharing_and_reset_pin_control_tb;
  logic clk_i, rst_i, por_i, lvd_rst_i, wdog_rst_i, ilop_rst_i, reset_pin_i, reset_pin_o, reset_pin_oe_n_o;
  logic sys_reset_o, bkgd_pin_i, bkgd_pin_o, bkgd_pin_oe_n_o, dbg_tx_valid_i, dbg_tx_bit_i, dbg_tx_ready_o;
  logic dbg_bit_tick_o, active_bkgd_o, irq_pin_i, irq_pull_up_o, irq_pull_down_o, irq_req_o, irq_level_o;
  logic self_clk_sel_o, stop_self_clk_o, osc_range_o, reg_wr_i, reg_rd_i, int_o, hold_rst, hold_bkgd, saw_hi;
  logic [7:0] pin_i, pin_o, pin_oe_n_o, pin_pu_o, port_data_i, port_dir_i, port_pue_i, port_rd_o, pin_in_o;
  logic [7:0] alt1_en_i, alt1_out_i, alt1_oe_i, alt2_en_i, alt2_out_i, alt2_oe_i, low_w, v;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
  int err_total = 0; // Mismatches seen.
  int n_compared = 0; // Comparisons made.
  pscrp_top pscrp_top_i (.clk_i, .rst_i, .por_i, .lvd_rst_i, .wdog_rst_i, .ilop_rst_i, .reset_pin_i,
    .reset_pin_o, .reset_pin_oe_n_o, .sys_reset_o, .bkgd_pin_i, .bkgd_pin_o, .bkgd_pin_oe_n_o, .dbg_tx_valid_i,
    .dbg_tx_bit_i, .dbg_tx_ready_o, .dbg_bit_tick_o, .active_bkgd_o, .irq_pin_i, .irq_pull_up_o,
    .irq_pull_down_o, .irq_req_o, .irq_level_o, .self_clk_sel_o, .stop_self_clk_o, .osc_range_o, .pin_i,
    .pin_o, .pin_oe_n_o, .pin_pu_o, .port_data_i, .port_dir_i, .port_pue_i, .port_rd_o, .alt1_en_i,
    .alt1_out_i, .alt1_oe_i, .alt2_en_i, .alt2_out_i, .alt2_oe_i, .pin_in_o, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .int_o);
  pscrp_partner pscrp_partner_i (.clk_i, .hold_rst_i(hold_rst), .hold_bkgd_i(hold_bkgd),
    .rst_oe_n_i(reset_pin_oe_n_o), .bkgd_o_i(bkgd_pin_o), .bkgd_oe_n_i(bkgd_pin_oe_n_o),
    .rst_pin_o(reset_pin_i), .bkgd_pin_o(bkgd_pin_i), .low_w_o(low_w), .saw_hi_o(saw_hi));
  // The bus clock, 100 ns period.
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Compares one value and reports a mismatch at once.
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One write cycle on the register port.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  // One read cycle; the data stand in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  // Holds reset for six cycles.
  task automatic do_rst();
    rst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask
  // Starts a reset sequence from source k, times the pin drive and checks the recorded cause;
  // x holds causes already pending, such as power-on after a fresh rst_i.
  task automatic seq(input int k, input int c, input logic [7:0] x = 8'h00);
    int n;
    n = 0;
    @(posedge clk_i);
    case (k)
      0: por_i <= 1'b1;
      1: lvd_rst_i <= 1'b1;
      2: wdog_rst_i <= 1'b1;
      3: ilop_rst_i <= 1'b1;
      default: hold_rst <= 1'b1;
    endcase
    for (int i = 0; i < 200; i++) begin
      @(posedge clk_i);
      {por_i, lvd_rst_i, wdog_rst_i, ilop_rst_i} <= 4'h0;
      if (i == 4) hold_rst <= 1'b0;
      if (reset_pin_oe_n_o === 1'b0) n++;
      else if (n > 0) break;
    end
    chk("drive cycles", 8'h22, n[7:0]);
    for (int i = 0; i < 60; i++) begin
      rd(pscrp_pkg::REG_STAT, v);
      if (v[1] === 1'b1) break;
    end
    chk("done flag", 8'h02, v & 8'h02);
    rd(pscrp_pkg::REG_CAUSE, v);
    chk("cause", (8'h01 << c) | x, v);
    wr(pscrp_pkg::REG_STAT, 8'h02);
  endtask
  // Sends one debug bit and checks the low time the pod measured.
  task automatic dbg(input logic b, input logic [7:0] w);
    @(posedge clk_i);
    dbg_tx_valid_i <= 1'b1;
    dbg_tx_bit_i <= b;
    for (int i = 0; i < 50; i++) begin
      @(posedge clk_i);
      if (dbg_tx_ready_o === 1'b1) break;
    end
    dbg_tx_valid_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    chk("bit low time", w, low_w);
  endtask
  // Cuts a hang short.
  initial begin
    #(100 * 10000);
    err_total++;
    print_verdict();
  end
  // Main sequence of tests.
  initial begin
    rst_i = 1'b1;
    {por_i, lvd_rst_i, wdog_rst_i, ilop_rst_i, dbg_tx_valid_i, dbg_tx_bit_i, irq_pin_i} = 7'h00;
    {reg_wr_i, reg_rd_i, hold_rst, hold_bkgd, reg_addr_i, reg_wdata_i} = 20'h0_0000;
    {pin_i, port_data_i, port_dir_i, port_pue_i} = 32'h0000_0000;
    {alt1_en_i, alt1_out_i, alt1_oe_i, alt2_en_i, alt2_out_i, alt2_oe_i} = 48'h0000_0000_0000;
    do_rst();
    #1 chk("self clock", 8'h01, {7'h00, self_clk_sel_o});
    chk("pin enables", 8'hFF, pin_oe_n_o);
    chk("pin pullups", 8'h00, pin_pu_o);
    chk("reset pin value", 8'h00, {7'h00, reset_pin_o});
    seq(0, pscrp_pkg::CAUSE_POR);
    chk("run mode", 8'h00, {7'h00, active_bkgd_o});
    hold_bkgd <= 1'b1;
    seq(1, pscrp_pkg::CAUSE_LVD);
    seq(2, pscrp_pkg::CAUSE_WDOG);
    seq(3, pscrp_pkg::CAUSE_ILOP);
    seq(4, pscrp_pkg::CAUSE_PIN);
    chk("mode kept", 8'h00, {7'h00, active_bkgd_o});
    // A low pin at the sample of an internal reset adds the pin error cause.
    @(posedge clk_i);
    lvd_rst_i <= 1'b1;
    @(posedge clk_i);
    lvd_rst_i <= 1'b0;
    repeat (pscrp_pkg::RST_DRIVE_CYC + pscrp_pkg::RST_SAMPLE_CYC - 3) @(posedge clk_i);
    hold_rst <= 1'b1;
    repeat (2) @(posedge clk_i);
    hold_rst <= 1'b0;
    repeat (8) @(posedge clk_i);
    rd(pscrp_pkg::REG_CAUSE, v);
    chk("pin error cause", (8'h01 << pscrp_pkg::CAUSE_PINERR) | (8'h01 << pscrp_pkg::CAUSE_LVD), v);
    $display("reset sources test done");
    do_rst();
    seq(2, pscrp_pkg::CAUSE_WDOG, 8'h01 << pscrp_pkg::CAUSE_POR);
    hold_bkgd <= 1'b0;
    rd(pscrp_pkg::REG_MODE, v);
    chk("background mode", 8'h01, v & 8'h01);
    dbg(1'b1, 8'h04);
    dbg(1'b0, 8'h0D);
    chk("speedup", 8'h01, {7'h00, saw_hi});
    chk("mode after debug", 8'h01, {7'h00, active_bkgd_o});
    $display("mode and debug test done");
    wr(pscrp_pkg::REG_CTRL, 8'h01);
    #1 chk("irq pulls", 8'h02, {6'h00, irq_pull_up_o, irq_pull_down_o});
    wr(pscrp_pkg::REG_CTRL, 8'h03);
    wr(pscrp_pkg::REG_MASK, 8'h01);
    #1 chk("irq pulls rising", 8'h01, {6'h00, irq_pull_up_o, irq_pull_down_o});
    irq_pin_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1 chk("irq request", 8'h01, {7'h00, irq_req_o});
    repeat (3) @(posedge clk_i);
    #1 chk("irq level and int", 8'h03, {6'h00, irq_level_o, int_o});
    wr(pscrp_pkg::REG_STAT, 8'h01);
    @(posedge clk_i);
    irq_pin_i <= 1'b0;
    #1 chk("int cleared", 8'h00, {7'h00, int_o});
    wr(pscrp_pkg::REG_CTRL, 8'h00);
    irq_pin_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rd(pscrp_pkg::REG_STAT, v);
    chk("irq off", 8'h00, {6'h00, irq_level_o, int_o} | (v & 8'h01));
    wr(pscrp_pkg::REG_CTRL, 8'h0C);
    #1 chk("clock ctrl", 8'h07, {5'h00, osc_range_o, stop_self_clk_o, self_clk_sel_o});
    wr(pscrp_pkg::REG_CTRL, 8'h10);
    #1 chk("generator clock", 8'h00, {5'h00, osc_range_o, stop_self_clk_o, self_clk_sel_o});
    rd(8'h10, v);
    chk("unmapped read", 8'h00, v);
    $display("irq and clock test done");
    @(posedge clk_i);
    port_dir_i <= 8'h0F;
    port_data_i <= 8'hA5;
    port_pue_i <= 8'hF0;
    {alt1_en_i, alt1_oe_i, alt1_out_i} <= 24'h30_3010;
    {alt2_en_i, alt2_oe_i, alt2_out_i} <= 24'h60_4000;
    pin_i <= 8'h3C;
    repeat (4) @(posedge clk_i);
    // Drivers: bits 3..0 port, bit 4 first function, bit 6 second function.
    #1 chk("pin enables mux", 8'hA0, pin_oe_n_o);
    chk("pin drive mux", 8'h15, pin_o & 8'h5F);
    chk("pin pullups mux", 8'hA0, pin_pu_o);
    chk("pin levels", 8'h3C, pin_in_o);
    chk("port read", 8'h35, port_rd_o);
    $display("pin sharing test done");
    print_verdict();
  end
endmodule

// ===== dv/pscrp_checker.sv
// Concurrent checks on the ports of the pin sharing and reset pin block.
`timescale 1ns/1ps
module pscrp_checker (
  input wire logic clk_i, // Bus clock.
  input wire logic rst_i, // Asynchronous reset.
  input wire logic reset_pin_oe_n_o, // Reset pin enable.
  input wire logic sys_reset_o, // Internal reset.
  input wire logic bkgd_pin_i, // Mode pin level.
  input wire logic bkgd_pin_o, // Mode pin drive value.
  input wire logic bkgd_pin_oe_n_o, // Mode pin enable.
  input wire logic dbg_tx_valid_i, // Debug bit offered.
  input wire logic dbg_tx_ready_o, // Debug bit taken.
  input wire logic dbg_bit_tick_o, // Bit boundary.
  input wire logic active_bkgd_o, // Background mode.
  input wire logic irq_pull_up_o, // IRQ pullup.
  input wire logic irq_pull_down_o, // IRQ pulldown.
  input wire logic [pscrp_pkg::NPINS-1:0] pin_oe_n_o, // Pin enables.
  input wire logic [pscrp_pkg::NPINS-1:0] pin_pu_o, // Pin pullups.
  input wire logic [pscrp_pkg::NPINS-1:0] alt2_en_i, // Second function on.
  input wire logic [pscrp_pkg::NPINS-1:0] alt2_oe_i // Second function drives.
);
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [6:0] lo_q; // Consecutive cycles of reset pin drive.
  // Counts how long the reset pin has been pulled low so far.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      lo_q <= 7'h00;
    end else if (!reset_pin_oe_n_o) begin
      lo_q <= lo_q + 7'h01;
    end else begin
      lo_q <= 7'h00;
    end
  end
  drive_len_a: assert property ($rose(reset_pin_oe_n_o) |-> lo_q == 7'h22)
    else $error("reset pin drive length wrong");
  release_hold_a: assert property ($rose(reset_pin_oe_n_o) |-> reset_pin_oe_n_o [*8])
    else $error("reset pin driven again too soon");
  mode_run_a: assert property ($fell(sys_reset_o) && bkgd_pin_i && $past(bkgd_pin_i, 2)
    && !$past(active_bkgd_o) |-> ##[0:2] !active_bkgd_o) else $error("run mode not kept");
  mode_hold_a: assert property ($changed(active_bkgd_o) |-> $past(sys_reset_o) || $past(sys_reset_o, 2))
    else $error("mode changed outside reset release");
  bit_time_a: assert property (dbg_tx_valid_i && dbg_tx_ready_o |-> ##[15:16] dbg_bit_tick_o)
    else $error("debug bit time wrong");
  bit_busy_a: assert property (dbg_tx_valid_i && dbg_tx_ready_o |=> !dbg_tx_ready_o [*8])
    else $error("debug sender ready inside a bit");
  speedup_a: assert property (bkgd_pin_o && !bkgd_pin_oe_n_o |-> $past(bkgd_pin_o) == 1'b0 ##1 bkgd_pin_oe_n_o)
    else $error("speedup pulse not brief");
  pull_excl_a: assert property (!(irq_pull_up_o && irq_pull_down_o))
    else $error("irq pullup and pulldown together");
  pin_reset_a: assert property ($past(rst_i) |-> &pin_oe_n_o && ~|pin_pu_o)
    else $error("shared pins not idle inputs after reset");
  alt2_wins_a: assert property (!sys_reset_o |-> ~|((pin_oe_n_o ^ ~alt2_oe_i) & alt2_en_i))
    else $error("second function not in control");
  cover property ($rose(reset_pin_oe_n_o));
  cover property ($rose(active_bkgd_o));
  cover property (dbg_bit_tick_o);
endmodule
bind pscrp_top pscrp_checker pscrp_checker_i (.clk_i, .rst_i, .reset_pin_oe_n_o, .sys_reset_o, .bkgd_pin_i,
  .bkgd_pin_o, .bkgd_pin_oe_n_o, .dbg_tx_valid_i, .dbg_tx_ready_o, .dbg_bit_tick_o, .active_bkgd_o,
  .irq_pull_up_o, .irq_pull_down_o, .pin_oe_n_o, .pin_pu_o, .alt2_en_i, .alt2_oe_i);

// ===== dv/pscrp_partner.sv
// Model of the reset switch and debug pod wired to the block's pins.
`timescale 1ns/1ps
module pscrp_partner (
  input wire logic clk_i, // Bus clock.
  input wire logic hold_rst_i, // Pull the reset pin low.
  input wire logic hold_bkgd_i, // Hold the mode pin low.
  input wire logic rst_oe_n_i, // Device pulls reset pin when low.
  input wire logic bkgd_o_i, // Device mode pin drive value.
  input wire logic bkgd_oe_n_i, // Device drives mode pin when low.
  output logic rst_pin_o, // Reset pin level.
  output logic bkgd_pin_o, // Mode pin level.
  output logic [7:0] low_w_o, // Width of the last low pulse.
  output logic saw_hi_o // A driven high pulse was seen.
);
  logic [7:0] cnt_q; // Low cycles counted so far.
  // Both pins carry pullups, so a released pin reads high.
  assign rst_pin_o = !(hold_rst_i || !rst_oe_n_i);
  assign bkgd_pin_o = !bkgd_oe_n_i ? bkgd_o_i : !hold_bkgd_i;
  // Measures each low pulse on the mode pin, as the pod's receiver does.
  always_ff @(posedge clk_i) begin
    cnt_q <= bkgd_pin_o ? 8'h00 : cnt_q + 8'h01;
    if (bkgd_pin_o && cnt_q != 8'h00) begin
      low_w_o <= cnt_q;
    end
    if (!bkgd_oe_n_i && bkgd_o_i) begin
      saw_hi_o <= 1'b1;
    end
  end
endmodule

// ===== hw/pscrp_pkg.sv
// Package of constants for the pin sharing and reset pin control block.
package pscrp_pkg;
  // Reset pin sequence timing in bus cycles.
  localparam int unsigned RST_DRIVE_CYC = 34; // Cycles the reset pin is pulled low.
  localparam int unsigned RST_SAMPLE_CYC = 38; // Cycles from release to the pin sample.
  localparam int unsigned CNT_W = 6; // Width of the sequence counter.
  // Debug link bit time in debug clock cycles.
  localparam int unsigned DBG_BIT_CYC = 16; // Debug clock cycles per bit time.
  localparam int unsigned DBG_SPEEDUP_CYC = 1; // Cycles of active high drive on a rising edge.
  // Number of shared port pins handled.
  localparam int unsigned NPINS = 8; // Shared pins in this instance.
  // Register offsets.
  localparam logic [7:0] REG_CAUSE = 8'h00; // Reset cause status.
  localparam logic [7:0] REG_CTRL = 8'h01; // IRQ and clock control.
  localparam logic [7:0] REG_STAT = 8'h02; // Interrupt status, write one to clear.
  localparam logic [7:0] REG_MASK = 8'h03; // Interrupt mask.
  localparam logic [7:0] REG_MODE = 8'h04; // Captured mode and pin levels.
  // Reset cause bit positions.
  localparam int unsigned CAUSE_POR = 0; // Power-on.
  localparam int unsigned CAUSE_PIN = 1; // External pin.
  localparam int unsigned CAUSE_LVD = 2; // Low voltage.
  localparam int unsigned CAUSE_WDOG = 3; // Watchdog.
  localparam int unsigned CAUSE_ILOP = 4; // Illegal opcode.
  localparam int unsigned CAUSE_PINERR = 5; // Pin read low after internal reset.
  // Control bit positions.
  localparam int unsigned CTRL_IRQ_EN = 0; // IRQ function enabled.
  localparam int unsigned CTRL_IRQ_RISE = 1; // IRQ detects rising edges.
  localparam int unsigned CTRL_RANGE = 2; // Oscillator range select.
  localparam int unsigned CTRL_STOP_SELF = 3; // Self clock for stop recovery.
  localparam int unsigned CTRL_CLK_EXT = 4; // Run from generator instead of self clock.
  // Interrupt status bit positions.
  localparam int unsigned IST_IRQ = 0; // IRQ pin edge.
  localparam int unsigned IST_RST = 1; // Reset sequence done.
  localparam logic [7:0] CTRL_RST = 8'h00; // Control reset value.
  // Reset sequence states.
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_DRIVE, SEQ_WAIT, SEQ_SAMPLE} pscrp_seq_e;
endpackage

// ===== hw/pscrp_top.sv
// Reset pin sequencer, mode capture, debug pin timing, IRQ pin and shared pin mux.
`timescale 1ns/1ps
module pscrp_top (
  input wire logic clk_i, // Bus clock, 10 MHz.
  input wire logic rst_i, // Asynchronous reset, active high.
  input wire logic por_i, // Power-on reset event, one cycle.
  input wire logic lvd_rst_i, // Low-voltage reset event, one cycle.
  input wire logic wdog_rst_i, // Watchdog reset event, one cycle.
  input wire logic ilop_rst_i, // Illegal opcode reset event, one cycle.
  input wire logic reset_pin_i, // Reset pin level.
  output logic reset_pin_o, // Reset pin drive value, always low.
  output logic reset_pin_oe_n_o, // Reset pin drive enable, low drives.
  output logic sys_reset_o, // Internal reset held to the core.
  input wire logic bkgd_pin_i, // Background/mode pin level.
  output logic bkgd_pin_o, // Background/mode pin drive value.
  output logic bkgd_pin_oe_n_o, // Background/mode pin enable, low drives.
  input wire logic dbg_tx_valid_i, // Debug bit to send is valid.
  input wire logic dbg_tx_bit_i, // Debug bit value to send.
  output logic dbg_tx_ready_o, // Debug sender can take a bit.
  output logic dbg_bit_tick_o, // Pulse at each debug bit time boundary.
  output logic active_bkgd_o, // Active background mode selected.
  input wire logic irq_pin_i, // External interrupt pin level.
  output logic irq_pull_up_o, // IRQ pin pullup enable.
  output logic irq_pull_down_o, // IRQ pin pulldown enable.
  output logic irq_req_o, // IRQ interrupt request pulse to the core, one cycle per detected edge.
  output logic irq_level_o, // IRQ pin level for the branch instructions.
  output logic self_clk_sel_o, // Core runs from the self clock.
  output logic stop_self_clk_o, // Self clock used for stop recovery.
  output logic osc_range_o, // Oscillator range select.
  input wire logic [pscrp_pkg::NPINS-1:0] pin_i, // Shared pin levels.
  output logic [pscrp_pkg::NPINS-1:0] pin_o, // Shared pin drive values.
  output logic [pscrp_pkg::NPINS-1:0] pin_oe_n_o, // Shared pin enables, low drives.
  output logic [pscrp_pkg::NPINS-1:0] pin_pu_o, // Shared pin pullups.
  input wire logic [pscrp_pkg::NPINS-1:0] port_data_i, // Port data register.
  input wire logic [pscrp_pkg::NPINS-1:0] port_dir_i, // Port direction, one is output.
  input wire logic [pscrp_pkg::NPINS-1:0] port_pue_i, // Port pullup enables.
  output logic [pscrp_pkg::NPINS-1:0] port_rd_o, // Port data register read value.
  input wire logic [pscrp_pkg::NPINS-1:0] alt1_en_i, // First alternate function enables.
  input wire logic [pscrp_pkg::NPINS-1:0] alt1_out_i, // First alternate outputs.
  input wire logic [pscrp_pkg::NPINS-1:0] alt1_oe_i, // First alternate output enables.
  input wire logic [pscrp_pkg::NPINS-1:0] alt2_en_i, // Second alternate function enables.
  input wire logic [pscrp_pkg::NPINS-1:0] alt2_out_i, // Second alternate outputs.
  input wire logic [pscrp_pkg::NPINS-1:0] alt2_oe_i, // Second alternate output enables.
  output logic [pscrp_pkg::NPINS-1:0] pin_in_o, // Synchronised pin levels to modules.
  input wire logic [7:0] reg_addr_i, // Register address.
  input wire logic [7:0] reg_wdata_i, // Register write data.
  input wire logic reg_wr_i, // Register write strobe.
  input wire logic reg_rd_i, // Register read strobe.
  output logic [7:0] reg_rdata_o, // Register read data, one cycle after the strobe.
  output logic int_o // Interrupt, high while an unmasked status bit is set.
);
  localparam logic [5:0] DRIVE_LAST = 6'(pscrp_pkg::RST_DRIVE_CYC - 1); // Last drive count.
  localparam logic [5:0] WAIT_LAST = 6'(pscrp_pkg::RST_SAMPLE_CYC - 1); // Last wait count.
  localparam logic [3:0] BIT_LAST = 4'(pscrp_pkg::DBG_BIT_CYC - 1); // Last bit-time count.
  localparam logic [3:0] SPEED_LAST = 4'(pscrp_pkg::DBG_SPEEDUP_CYC); // Speedup ends here.

  // Synchronisers for pin inputs; only stage two is read.
  logic rpin_s1_q, rpin_s2_q; // Reset pin sync, reset high as the pin idles high.
  logic bkgd_s1_q, bkgd_s2_q; // Background pin sync.
  logic irq_s1_q, irq_s2_q; // IRQ pin sync.
  logic [pscrp_pkg::NPINS-1:0] pin_s1_q, pin_s2_q; // Shared pins sync.

  // Two flip-flop synchronisers for all outside levels.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rpin_s1_q <= 1'b1;
      rpin_s2_q <= 1'b1;
      bkgd_s1_q <= 1'b1;
      bkgd_s2_q <= 1'b1;
      irq_s1_q <= 1'b0;
      irq_s2_q <= 1'b0;
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      rpin_s1_q <= reset_pin_i;
      rpin_s2_q <= rpin_s1_q;
      bkgd_s1_q <= bkgd_pin_i;
      bkgd_s2_q <= bkgd_s1_q;
      irq_s1_q <= irq_pin_i;
      irq_s2_q <= irq_s1_q;
      pin_s1_q <= pin_i;
      pin_s2_q <= pin_s1_q;
    end
  end
  wire rpin_lvl = rpin_s2_q; // Synchronised reset pin.

  // Reset sequence state.
  pscrp_pkg::pscrp_seq_e seq_q, seq_d; // Sequencer state.
  logic [pscrp_pkg::CNT_W-1:0] cnt_q, cnt_d; // Sequence counter.
  logic internal_q, internal_d; // Current reset came from inside.
  logic [5:0] pend_q; // Causes gathered during this sequence.
  logic [5:0] cause_q; // Reset cause status register.
  logic mode_q; // Captured mode select level, low is background.
  logic seq_done; // Pulse when the sequence ends.

  // An internal request wins over a pin event in the same cycle, so the pin cause is not doubled.
  wire int_evt = lvd_rst_i | wdog_rst_i | ilop_rst_i | por_i; // Internal reset request.
  wire pin_evt = (seq_q == pscrp_pkg::SEQ_IDLE) & ~rpin_lvl; // External pin pulled low.

  // Next state of the reset sequencer.
  always_comb begin
    seq_d = seq_q;
    cnt_d = cnt_q;
    internal_d = internal_q;
    seq_done = 1'b0;
    case (seq_q)
      pscrp_pkg::SEQ_IDLE: begin
        if (int_evt | pin_evt) begin
          seq_d = pscrp_pkg::SEQ_DRIVE;
          cnt_d = '0;
          internal_d = int_evt;
        end
      end
      pscrp_pkg::SEQ_DRIVE: begin
        cnt_d = cnt_q + 6'd1;
        if (cnt_q == DRIVE_LAST) begin
          seq_d = pscrp_pkg::SEQ_WAIT;
          cnt_d = '0;
        end
      end
      pscrp_pkg::SEQ_WAIT: begin
        cnt_d = cnt_q + 6'd1;
        if (cnt_q == WAIT_LAST) begin
          seq_d = pscrp_pkg::SEQ_SAMPLE;
        end
      end
      pscrp_pkg::SEQ_SAMPLE: begin
        // A low pin from an outside source holds reset until it rises.
        if (rpin_lvl | internal_q) begin
          seq_d = pscrp_pkg::SEQ_IDLE;
          seq_done = 1'b1;
        end
      end
      default: seq_d = pscrp_pkg::SEQ_IDLE;
    endcase
  end

  // Sequencer registers.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      seq_q <= pscrp_pkg::SEQ_IDLE;
      cnt_q <= '0;
      internal_q <= 1'b0;
    end else begin
      seq_q <= seq_d;
      cnt_q <= cnt_d;
      internal_q <= internal_d;
    end
  end

  // Causes seen during the sequence; latched into status at the end.
  wire [5:0] cause_evt = {(seq_q == pscrp_pkg::SEQ_SAMPLE) & internal_q & ~rpin_lvl,
                          ilop_rst_i, wdog_rst_i, lvd_rst_i,
                          pin_evt & ~int_evt, por_i};
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pend_q <= 6'h01;
      cause_q <= '0;
    end else if (seq_done) begin
      // The closing cycle's events join in; the low-pin sample exists only in that cycle.
      cause_q <= pend_q | cause_evt;
      pend_q <= '0;
    end else begin
      pend_q <= pend_q | cause_evt;
    end
  end

  // Mode pin captured once at the release edge of the internal reset.
  logic sys_reset_q; // Internal reset level.
  logic mode_taken_q; // Mode already captured.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sys_reset_q <= 1'b1;
      mode_q <= 1'b1;
      mode_taken_q <= 1'b0;
    end else begin
      sys_reset_q <= (seq_d != pscrp_pkg::SEQ_IDLE);
      // Only the end of a sequence is a true release edge: at rst_i release the
      // synchroniser still holds its reset value, not the level on the pin.
      if (seq_done & ~mode_taken_q) begin
        mode_q <= bkgd_s2_q;
        mode_taken_q <= 1'b1;
      end
    end
  end
  assign sys_reset_o = sys_reset_q;
  assign active_bkgd_o = ~mode_q;
  // The pin is only ever pulled low; its pullup makes the high level.
  assign reset_pin_o = 1'b0;
  assign reset_pin_oe_n_o = ~(seq_q == pscrp_pkg::SEQ_DRIVE);

  // Debug link bit sender: low start, rise timed by the data bit, speedup high at the rise.
  logic [3:0] bcnt_q; // Bit-time counter.
  logic busy_q; // Bit in progress.
  logic bit_q; // Bit being sent.
  wire dbg_go = ~sys_reset_q & mode_taken_q; // Pin serves debug only out of reset.
  assign dbg_tx_ready_o = dbg_go & ~busy_q;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bcnt_q <= '0;
      busy_q <= 1'b0;
      bit_q <= 1'b0;
    end else if (busy_q) begin
      bcnt_q <= bcnt_q + 4'd1;
      if (bcnt_q == BIT_LAST) begin
        busy_q <= 1'b0;
      end
    end else if (dbg_tx_valid_i & dbg_tx_ready_o) begin
      busy_q <= 1'b1;
      bit_q <= dbg_tx_bit_i;
      bcnt_q <= '0;
    end
  end
  assign dbg_bit_tick_o = busy_q & (bcnt_q == BIT_LAST);
  // Low for the first quarter; a one rises early, a zero late, each with a driven speedup.
  wire [3:0] rise_at = bit_q ? 4'd4 : 4'd13; // Cycle at which the line rises.
  wire drive_low = busy_q & (bcnt_q < rise_at);
  wire drive_hi = busy_q & (bcnt_q >= rise_at) & (bcnt_q < rise_at + SPEED_LAST);
  assign bkgd_pin_o = drive_hi;
  assign bkgd_pin_oe_n_o = ~(dbg_go & (drive_low | drive_hi));

  // Control, interrupt status and mask registers.
  logic [7:0] ctrl_q; // Control register.
  logic [1:0] ist_q; // Sticky interrupt status.
  logic [1:0] imask_q; // Interrupt mask.
  logic irq_prev_q; // Previous IRQ level for edge detect.
  wire irq_en = ctrl_q[pscrp_pkg::CTRL_IRQ_EN];
  wire irq_rise = ctrl_q[pscrp_pkg::CTRL_IRQ_RISE];
  wire irq_edge = irq_en & (irq_rise ? (irq_s2_q & ~irq_prev_q) : (~irq_s2_q & irq_prev_q));
  wire [1:0] ist_set = {seq_done, irq_edge};
  wire wr_ctrl = reg_wr_i & (reg_addr_i == pscrp_pkg::REG_CTRL);
  wire wr_stat = reg_wr_i & (reg_addr_i == pscrp_pkg::REG_STAT);
  wire wr_mask = reg_wr_i & (reg_addr_i == pscrp_pkg::REG_MASK);

  // Register writes; a set wins over a clear in the same cycle.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q <= pscrp_pkg::CTRL_RST;
      ist_q <= '0;
      imask_q <= '0;
      irq_prev_q <= 1'b0;
    end else begin
      irq_prev_q <= irq_s2_q;
      if (wr_ctrl) begin
        ctrl_q <= reg_wdata_i;
      end
      if (wr_mask) begin
        imask_q <= reg_wdata_i[1:0];
      end
      ist_q <= (ist_q & ~(wr_stat ? reg_wdata_i[1:0] : 2'b00)) | ist_set;
    end
  end
  assign int_o = |(ist_q & imask_q);
  assign irq_req_o = irq_edge;
  assign irq_level_o = irq_en & irq_s2_q;
  // The pull follows the edge sense so that an idle pin never looks active.
  assign irq_pull_up_o = irq_en & ~irq_rise;
  assign irq_pull_down_o = irq_en & irq_rise;
  assign osc_range_o = ctrl_q[pscrp_pkg::CTRL_RANGE];
  assign stop_self_clk_o = ctrl_q[pscrp_pkg::CTRL_STOP_SELF];
  assign self_clk_sel_o = sys_reset_q | ~ctrl_q[pscrp_pkg::CTRL_CLK_EXT];

  // Read decoding.
  logic [7:0] rd_mux; // Selected read value.
  always_comb begin
    if (reg_addr_i == pscrp_pkg::REG_CAUSE) begin
      rd_mux = {2'b00, cause_q};
    end else if (reg_addr_i == pscrp_pkg::REG_CTRL) begin
      rd_mux = ctrl_q;
    end else if (reg_addr_i == pscrp_pkg::REG_STAT) begin
      rd_mux = {6'h00, ist_q};
    end else if (reg_addr_i == pscrp_pkg::REG_MASK) begin
      rd_mux = {6'h00, imask_q};
    end else if (reg_addr_i == pscrp_pkg::REG_MODE) begin
      rd_mux = {5'h00, irq_s2_q, bkgd_s2_q, ~mode_q};
    end else begin
      rd_mux = 8'h00; // Unmapped reads zero.
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= '0;
    end else begin
      reg_rdata_o <= reg_rd_i ? rd_mux : 8'h00;
    end
  end

  // Shared pin mux: second alternate over first over port.
  for (genvar i = 0; i < pscrp_pkg::NPINS; i++) begin : g_pin
    wire oe = alt2_en_i[i] ? alt2_oe_i[i] : (alt1_en_i[i] ? alt1_oe_i[i] : port_dir_i[i]);
    wire dv = alt2_en_i[i] ? alt2_out_i[i] : (alt1_en_i[i] ? alt1_out_i[i] : port_data_i[i]);
    // Internal reset forces enables and pullups off, so pins come up as bare inputs.
    assign pin_oe_n_o[i] = sys_reset_q | ~oe;
    assign pin_o[i] = dv;
    assign pin_pu_o[i] = ~sys_reset_q & ~oe & port_pue_i[i];
    // The read uses the direction bit even while a peripheral owns the pin.
    assign port_rd_o[i] = port_dir_i[i] ? port_data_i[i] : pin_s2_q[i];
  end
  assign pin_in_o = pin_s2_q;
endmodule
